// [src/acio_pkg.sv]
// constants for the address-capable 8-bit i/o port and its avalon slave
// assumes one 100 MHz core clock; register space is word addressed
//
// Function
// [RULE1] - each pin has a write-only direction bit; reading it returns undefined.
// [RULE2] - direction clears on power-on reset and hardware standby; kept otherwise.
// [RULE3] - modes 1, 4, 5: every pin is an address output, direction ignored.
// [RULE4] - modes 2, 6: direction one gives address output, zero gives input.
// [RULE5] - modes 3, 7: direction one gives general output, zero gives input.
// [RULE6] - software standby: address outputs hold level or float, per external bit.
// [RULE7] - output data register is read/write, cleared like direction, kept otherwise.
// [RULE8] - pin-state register is read-only; software writes outputs to output data.
// [RULE9] - pin-state read gives output data where direction one, pin level otherwise.
// [RULE10] - pin-state follows pins after reset; holds through manual reset, software standby.
// [RULE11] - modes 2, 3, 6, 7: pull-up on only for input pins with control set.
// [RULE12] - pull-up control is read/write, cleared like direction, kept otherwise.
// [RULE13] - reduced variant has no port registers; pins are address outputs always.
// [RULE14] - modes 1, 4, 5: pull-ups stay off whatever the control bits say.
package acio_pkg;

  localparam int          PORT_W     = 8;
  localparam int          BUS_AW     = 18;
  localparam int          BUS_DW     = 32;
  localparam int          SYNC_W     = 12;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_DIR    = 16'hfeba;
  localparam logic [15:0] IDX_LEVEL  = 16'hff5a;
  localparam logic [15:0] IDX_ODATA  = 16'hff6a;
  localparam logic [15:0] IDX_PULLUP = 16'hff71;

  localparam logic [7:0]  DIR_RST    = 8'h00;
  localparam logic [7:0]  ODATA_RST  = 8'h00;
  localparam logic [7:0]  PULLUP_RST = 8'h00;
  localparam logic [7:0]  LEVEL_RST  = 8'h00;
  // value returned by the write-only direction register
  localparam logic [7:0]  DIR_UNDEF  = 8'hff;
  localparam logic [7:0]  ALL_ONES   = 8'hff;

  localparam int          MODE_W     = 3;

  typedef enum logic [1:0] {
    FN_INPUT,
    FN_ADDR_OUT,
    FN_GEN_OUT
  } pin_fn_t;

endpackage : acio_pkg

// [src/acio_sync2.sv]
// two-flop synchroniser for a group of asynchronous levels
// assumes the inputs change slowly compared with the core clock
`timescale 1ns/100ps
`default_nettype none
module acio_sync2 #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : acio_sync2
`default_nettype wire

// [src/acio_port.sv]
// address-capable 8-bit i/o port with an avalon-mm register slave
// assumes i_addr_bus is on the core clock; pins and straps are asynchronous
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module acio_port
  import acio_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [BUS_DW-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [BUS_DW-1:0] o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // system state
  input  wire logic [MODE_W-1:0] i_op_mode,
  input  wire logic              i_hw_standby,
  input  wire logic              i_sw_standby,
  input  wire logic              i_manual_reset,
  input  wire logic              i_standby_output_hold,
  input  wire logic              i_reduced_variant,
  // internal address bus
  input  wire logic [PORT_W-1:0] i_addr_bus,
  // pins
  input  wire logic [PORT_W-1:0] i_pin_in,
  output logic      [PORT_W-1:0] o_pin_out,
  output logic      [PORT_W-1:0] o_pin_oe,
  output logic      [PORT_W-1:0] o_pin_pullup
);

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_out;
  logic [PORT_W-1:0] pin_s;
  logic [MODE_W-1:0] mode_s;
  logic              hw_stby_s;
  logic              sw_stby_s;
  logic              man_rst_s;
  logic              hold_s;
  logic              reduced_s;

  logic [PORT_W-1:0] dir_r;
  logic [PORT_W-1:0] odata_r;
  logic [PORT_W-1:0] pullup_ctl_r;
  logic [PORT_W-1:0] level_r;
  logic              wait_r;
  logic [BUS_DW-1:0] rdata_r;

  logic              mode_addr_all;
  logic              mode_addr_sel;
  logic              mode_gen_sel;
  logic              pullup_mode;
  logic              req;
  logic              wr_go;
  logic              lane0;
  logic [15:0]       reg_idx;
  logic              idx_ok;
  logic [PORT_W-1:0] mix_level;
  logic [PORT_W-1:0] rd_byte;
  logic [PORT_W-1:0] pin_out_nxt;
  logic [PORT_W-1:0] pin_oe_nxt;
  logic [PORT_W-1:0] pullup_nxt;
  pin_fn_t           pin_fn [PORT_W];

  // every pin-facing level is resynchronised before use
  assign async_in = {i_pin_in, i_hw_standby, i_sw_standby,
                     i_manual_reset, i_standby_output_hold};

  acio_sync2 #(
    .W(SYNC_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    (async_in),
    .o_sync     (sync_out)
  );

  assign pin_s     = sync_out[SYNC_W-1:4];
  assign hw_stby_s = sync_out[3];
  assign sw_stby_s = sync_out[2];
  assign man_rst_s = sync_out[1];
  assign hold_s    = sync_out[0];

  // mode and variant straps get their own synchroniser
  acio_sync2 #(
    .W(MODE_W + 1)
  ) u_sync_strap (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_op_mode, i_reduced_variant}),
    .o_sync     ({mode_s, reduced_s})
  );

  // mode decode
  always_comb begin
    mode_addr_all = 1'b0;
    mode_addr_sel = 1'b0;
    mode_gen_sel  = 1'b0;
    case (mode_s)
      3'h1, 3'h4, 3'h5: mode_addr_all = 1'b1;
      3'h2, 3'h6:       mode_addr_sel = 1'b1;
      3'h3, 3'h7:       mode_gen_sel  = 1'b1;
      default:          mode_addr_all = 1'b0;
    endcase
  end
  assign pullup_mode = (mode_addr_sel | mode_gen_sel) & ~reduced_s;

  // bus decode; a register sits in the low byte of its word
  assign req     = i_avs_read | i_avs_write;
  assign reg_idx = i_avs_address[BUS_AW-1:2];
  assign idx_ok  = (i_avs_address[1:0] == 2'h0) & ~reduced_s;
  assign lane0   = i_avs_byteenable[0];
  assign wr_go   = i_avs_write & ~wait_r & idx_ok & lane0 & ~hw_stby_s;

  // one wait cycle, then a single low cycle of waitrequest
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // direction register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_r <= DIR_RST;                                        // [RULE2]
    end else if (hw_stby_s) begin
      dir_r <= DIR_RST;                                        // [RULE2]
    end else if (wr_go && reg_idx == IDX_DIR) begin
      dir_r <= i_avs_writedata[PORT_W-1:0];                    // [RULE1]
    end
  end

  // output data register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      odata_r <= ODATA_RST;                                    // [RULE7]
    end else if (hw_stby_s) begin
      odata_r <= ODATA_RST;                                    // [RULE7]
    end else if (wr_go && reg_idx == IDX_ODATA) begin
      odata_r <= i_avs_writedata[PORT_W-1:0];                  // [RULE7]
    end
  end

  // pull-up control register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pullup_ctl_r <= PULLUP_RST;                              // [RULE12]
    end else if (hw_stby_s) begin
      pullup_ctl_r <= PULLUP_RST;                              // [RULE12]
    end else if (wr_go && reg_idx == IDX_PULLUP) begin
      pullup_ctl_r <= i_avs_writedata[PORT_W-1:0];             // [RULE12]
    end
  end

  // pin-state view: output data where direction is one, pin level where it is zero
  assign mix_level = (dir_r & odata_r) | (~dir_r & pin_s);     // [RULE9]

  // frozen through manual reset and software standby unless hardware standby is set
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_r <= LEVEL_RST;
    end else if (hw_stby_s || !(man_rst_s || sw_stby_s)) begin
      level_r <= mix_level;                                    // [RULE10]
    end
  end

  // writes to the pin-state index fall through and change nothing
  always_comb begin
    rd_byte = '0;
    if (idx_ok) begin
      case (reg_idx)
        IDX_DIR:    rd_byte = DIR_UNDEF;                       // [RULE1]
        IDX_LEVEL:  rd_byte = level_r;                         // [RULE8]
        IDX_ODATA:  rd_byte = odata_r;
        IDX_PULLUP: rd_byte = pullup_ctl_r;
        default:    rd_byte = '0;
      endcase
    end
  end

  // read data is captured in the wait cycle and stands while waitrequest low
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= '0;
    end else if (i_avs_read && wait_r) begin
      rdata_r <= {{(BUS_DW - PORT_W){1'b0}}, rd_byte};
    end
  end

  // per-pin function
  for (genvar b = 0; b < PORT_W; b++) begin : g_pin
    always_comb begin
      if (reduced_s || mode_addr_all) begin
        pin_fn[b] = FN_ADDR_OUT;                               // [RULE3] [RULE13]
      end else if (mode_addr_sel) begin
        pin_fn[b] = dir_r[b] ? FN_ADDR_OUT : FN_INPUT;         // [RULE4]
      end else if (mode_gen_sel) begin
        pin_fn[b] = dir_r[b] ? FN_GEN_OUT : FN_INPUT;          // [RULE5]
      end else begin
        pin_fn[b] = FN_INPUT;
      end
    end

    always_comb begin
      pin_out_nxt[b] = 1'b0;
      pin_oe_nxt[b]  = 1'b0;
      case (pin_fn[b])
        FN_ADDR_OUT: begin
          // standby either freezes the last address level or floats it
          pin_out_nxt[b] = sw_stby_s ? o_pin_out[b] : i_addr_bus[b];
          pin_oe_nxt[b]  = ~sw_stby_s | hold_s;                // [RULE6]
        end
        FN_GEN_OUT: begin
          pin_out_nxt[b] = odata_r[b];
          pin_oe_nxt[b]  = 1'b1;
        end
        default: begin
          pin_out_nxt[b] = 1'b0;
          pin_oe_nxt[b]  = 1'b0;
        end
      endcase
      if (hw_stby_s) begin
        pin_oe_nxt[b] = 1'b0;
      end
    end

    assign pullup_nxt[b] = pullup_mode & ~dir_r[b] &
                           pullup_ctl_r[b];                    // [RULE11] [RULE14]
  end

  // pin drivers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_out    <= '0;
      o_pin_oe     <= '0;
      o_pin_pullup <= '0;
    end else begin
      o_pin_out    <= pin_out_nxt;
      o_pin_oe     <= pin_oe_nxt;
      o_pin_pullup <= pullup_nxt;
    end
  end

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;

  // assertions

  sequence s_wait_ack;
    !wait_r ##1 wait_r;
  endsequence

  sequence s_dir_write;
    wr_go && reg_idx == IDX_DIR;
  endsequence

  property p_handshake;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (req && wait_r) |=> s_wait_ack;
  endproperty

  bus_handshake_a: assert property (p_handshake)
    else $error("waitrequest did not pulse low for one cycle");

  dir_write_a: assert property ( // [RULE1]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      s_dir_write |=> dir_r == $past(i_avs_writedata[PORT_W-1:0]))
    else $error("direction write not stored");

  hw_clear_a: assert property ( // [RULE2]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      hw_stby_s |=> (dir_r == DIR_RST && odata_r == ODATA_RST
                     && pullup_ctl_r == PULLUP_RST))
    else $error("registers not cleared in hardware standby");

  addr_all_oe_a: assert property ( // [RULE3]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_addr_all && !sw_stby_s && !hw_stby_s)
        |=> (o_pin_oe == ALL_ONES && o_pin_out == $past(i_addr_bus)))
    else $error("address output mode not driving all pins");

  gen_out_a: assert property ( // [RULE5]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_gen_sel && !reduced_s && !hw_stby_s)
        |=> (o_pin_oe == $past(dir_r) &&
             (o_pin_out & o_pin_oe) == ($past(odata_r) & $past(dir_r))))
    else $error("general output mode drives wrong pins");

  standby_float_a: assert property ( // [RULE6]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_addr_all && sw_stby_s && !hold_s) |=> o_pin_oe == '0)
    else $error("address pins not floated in software standby");

  pullup_off_a: assert property ( // [RULE14]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      mode_addr_all |=> o_pin_pullup == '0)
    else $error("pull-up on in an address-only mode");

  pullup_on_a: assert property ( // [RULE11]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      pullup_mode |=> o_pin_pullup == ($past(pullup_ctl_r) & ~$past(dir_r)))
    else $error("pull-up state wrong for input pins");

  level_ro_a: assert property ( // [RULE8]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_avs_write && !wait_r && reg_idx == IDX_LEVEL && !hw_stby_s)
        |=> $stable(odata_r) && $stable(dir_r))
    else $error("write to pin-state register changed state");

  level_read_a: assert property ( // [RULE9]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_avs_read && wait_r && idx_ok && reg_idx == IDX_LEVEL)
        |=> o_avs_readdata[PORT_W-1:0] == $past(level_r) ##1 wait_r)
    else $error("pin-state read returned wrong value");

  level_hold_a: assert property ( // [RULE10]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (sw_stby_s && !hw_stby_s) |=> $stable(level_r))
    else $error("pin-state changed during software standby");

  reduced_a: assert property ( // [RULE13]
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (reduced_s && !sw_stby_s && !hw_stby_s) |=> o_pin_oe == ALL_ONES)
    else $error("reduced variant not driving address outputs");

endmodule : acio_port
`default_nettype wire

// [test/pin_model.sv]
// external pin model: resolves each port pin from all its drivers
// port drive overrides the bench drive wherever the port enables its output
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  // a floating pin shows the inverse of the port value, never a lucky 0
  always_comb begin
    o_level = (i_oe & i_out)
            | (~i_oe & i_ext_en & i_ext)
            | (~i_oe & ~i_ext_en & i_pullup)
            | (~i_oe & ~i_ext_en & ~i_pullup & ~i_out);
  end
endmodule : pin_model
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the address-capable port and its avalon slave
// assumes pin_model on the pins; seed of the lfsr is fixed
`timescale 1ns/100ps
`default_nettype none
module tb;
  import acio_pkg::*;
  logic        core_clk, reset_n, rd_en, wr_en, waitreq;
  logic [17:0] address;
  logic [31:0] wdata, readdata;
  logic [2:0]  op_mode;
  logic        hw_sb, sw_sb, man_rst, hold, reduced;
  logic [7:0]  addr_bus, pin_in, pin_out, pin_oe, pin_pu, ext, ext_en;
  logic [7:0]  got, d, o, p, e, eo, eu, lv;
  logic [15:0] lf;
  logic [3:0]  be;
  int          fails, checked;

  acio_port dut (.i_core_clk(core_clk), .i_reset_n(reset_n),
    .i_avs_address(address), .i_avs_read(rd_en), .i_avs_write(wr_en),
    .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
    .i_op_mode(op_mode), .i_hw_standby(hw_sb), .i_sw_standby(sw_sb),
    .i_manual_reset(man_rst), .i_standby_output_hold(hold),
    .i_reduced_variant(reduced), .i_addr_bus(addr_bus), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_pullup(pin_pu));

  pin_model pins (.i_out(pin_out), .i_oe(pin_oe), .i_pullup(pin_pu),
    .i_ext(ext), .i_ext_en(ext_en), .o_level(pin_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  function automatic logic [7:0] exp_oe(input int m, input logic [7:0] d);
    return (m == 1 || m == 4 || m == 5) ? 8'hff : d;
  endfunction : exp_oe

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // one extra edge after release keeps two requests apart
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    wdata   <= {24'h000000, wd};
    rd_en   <= ~wr;
    wr_en   <= wr;
    @(posedge core_clk);
    while (waitreq !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 40) chk(8'h00, 8'h01);
    rd = readdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [7:0] t;
    bus(1'b1, idx, v, t);
  endtask : wr

  task automatic settle;
    repeat (6) @(posedge core_clk);
  endtask : settle

  initial begin
    repeat (20000) @(posedge core_clk);
    chk(8'h00, 8'h01);
    tally_and_finish();
  end

  initial begin
    lf = 16'h43fa;
    reset_n <= 1'b0; rd_en <= 1'b0; wr_en <= 1'b0; be <= 4'h1;
    address <= 18'h00000; wdata <= 32'h00000000;
    op_mode <= 3'h0; hw_sb <= 1'b0; sw_sb <= 1'b0; man_rst <= 1'b0;
    hold <= 1'b1; reduced <= 1'b0; addr_bus <= 8'h00;
    ext <= 8'h00; ext_en <= 8'hff;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, 8'h00);
    bus(1'b0, IDX_PULLUP, 8'h00, got); chk(got, 8'h00);
    bus(1'b0, IDX_DIR, 8'h00, got); chk(got, DIR_UNDEF);
    bus(1'b0, 16'h0001, 8'h00, got); chk(got, 8'h00);
    $display("test reset done");
    for (int m = 1; m < 8; m++) begin
      lf = nxt(lf); d = lf[7:0]; o = lf[15:8];
      lf = nxt(lf); p = lf[7:0]; e = lf[15:8];
      lf = nxt(lf);
      // released pins lean on their pull-up, so the level is known
      op_mode <= m[2:0]; addr_bus <= lf[7:0]; ext <= e; ext_en <= ~p;
      wr(IDX_DIR, d); wr(IDX_ODATA, o); wr(IDX_PULLUP, p);
      settle();
      eo = exp_oe(m, d);
      eu = (m == 3 || m == 7) ? o : lf[7:0];
      chk(pin_oe, eo);
      chk(pin_out & eo, eu & eo);
      chk(pin_pu, (eo == 8'hff) ? 8'h00 : (~d & p));
      wr(IDX_LEVEL, ~o);
      lv = (d & o) | (~d & ((eo & eu) | (~eo & (p | e))));
      bus(1'b0, IDX_LEVEL, 8'h00, got); chk(got, lv);
      bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, o);
      bus(1'b0, IDX_PULLUP, 8'h00, got); chk(got, p);
    end
    $display("test modes done");
    man_rst <= 1'b1; ext <= ~e;
    settle();
    bus(1'b0, IDX_LEVEL, 8'h00, got); chk(got, lv);
    man_rst <= 1'b0;
    settle();
    bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, o);
    bus(1'b0, IDX_PULLUP, 8'h00, got); chk(got, p);
    chk(pin_oe, d);
    $display("test manual reset done");
    op_mode <= 3'h1; addr_bus <= 8'h3c;
    settle();
    sw_sb <= 1'b1;
    settle();
    addr_bus <= 8'hc3;
    settle();
    chk(pin_out, 8'h3c);
    chk(pin_oe, 8'hff);
    sw_sb <= 1'b0; hold <= 1'b0;
    settle();
    sw_sb <= 1'b1;
    settle();
    chk(pin_oe, 8'h00);
    sw_sb <= 1'b0; op_mode <= 3'h7; ext <= 8'h5a; ext_en <= 8'hff;
    settle();
    chk(pin_oe, d);
    $display("test software standby done");
    hw_sb <= 1'b1;
    settle();
    chk(pin_oe, 8'h00);
    hw_sb <= 1'b0;
    settle();
    chk(pin_oe, 8'h00);
    chk(pin_pu, 8'h00);
    bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, 8'h00);
    bus(1'b0, IDX_PULLUP, 8'h00, got); chk(got, 8'h00);
    bus(1'b0, IDX_LEVEL, 8'h00, got); chk(got, 8'h5a);
    // a write without lane 0 enabled must leave the register alone
    be <= 4'h0;
    wr(IDX_ODATA, 8'h77);
    be <= 4'h1;
    bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, 8'h00);
    $display("test hardware standby done");
    reduced <= 1'b1; addr_bus <= 8'h96;
    settle();
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'h96);
    wr(IDX_ODATA, 8'h77);
    bus(1'b0, IDX_ODATA, 8'h00, got); chk(got, 8'h00);
    reduced <= 1'b0;
    $display("test reduced variant done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
